/* pao_core.sv */
`timescale 1ns/100ps
module pao_core
    import pao_pkg::*;
#(
    parameter int PINS = NUM_PINS
)(
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output logic [1:0] s_axi_bresp,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    input wire logic sleep_i,
    input wire logic [PINS-1:0] pullup_override_en_i,
    input wire logic [PINS-1:0] pullup_override_val_i,
    input wire logic [PINS-1:0] direction_override_en_i,
    input wire logic [PINS-1:0] direction_override_val_i,
    input wire logic [PINS-1:0] pin_value_override_en_i,
    input wire logic [PINS-1:0] pin_value_override_val_i,
    input wire logic [PINS-1:0] latch_toggle_override_en_i,
    input wire logic [PINS-1:0] input_enable_override_en_i,
    input wire logic [PINS-1:0] input_enable_override_val_i,
    input wire logic [PINS-1:0] pad_in_i,
    output logic [PINS-1:0] pad_out_o,
    output logic [PINS-1:0] pad_oe_o,
    output logic [PINS-1:0] pullup_en_o,
    output logic [PINS-1:0] input_en_o,
    output logic [PINS-1:0] alt_func_pin_input_o,
    output logic global_pullup_off_o,
    output logic brownout_sleep_off_o,
    output logic brownout_sleep_unlock_o
);

    pao_core_s s_reg;
    pao_core_s s_next;
    logic [PINS-1:0] pin_sync;
    logic [PINS-1:0] sw_toggle;
    logic [PINS-1:0] latch_base;
    logic wr_fire;
    logic [1:0] wr_resp;
    logic [31:0] rd_word;
    logic [1:0] rd_resp;

    default clocking @(posedge clk_i);
    endclocking
    default disable iff (reset_i);

    // ****************************************
    // Bus handshakes
    // ****************************************
    assign s_axi_awready = !s_reg.aw_held && !s_reg.bvalid;
    assign s_axi_wready = !s_reg.w_held && !s_reg.bvalid;
    assign s_axi_arready = !s_reg.rvalid;
    assign s_axi_bvalid = s_reg.bvalid;
    assign s_axi_bresp = s_reg.bresp;
    assign s_axi_rvalid = s_reg.rvalid;
    assign s_axi_rdata = s_reg.rdata;
    assign s_axi_rresp = s_reg.rresp;
    assign wr_fire = s_reg.aw_held && s_reg.w_held && !s_reg.bvalid;
    assign global_pullup_off_o = s_reg.mcu[MCU_GLOBAL_PULLUP_OFF_BIT];
    assign brownout_sleep_off_o = s_reg.mcu[MCU_BROWNOUT_SLEEP_OFF_BIT];
    assign brownout_sleep_unlock_o = s_reg.mcu[MCU_BROWNOUT_SLEEP_UNLOCK_BIT];

    // ****************************************
    // Read decode
    // ****************************************
    always_comb begin
        rd_word = 32'h0000_0000;
        rd_resp = AXI_RESP_OKAY;
        unique case (s_axi_araddr[7:0])
            OFS_MCU_CONTROL: rd_word[7:0] = s_reg.mcu & MCU_CONTROL_RW_MASK;
            OFS_PORT_CONTROL: rd_word[7:0] = s_reg.pcr;
            OFS_A_DIRECTION: rd_word[7:0] = s_reg.dir[7:0];
            OFS_A_LATCH: rd_word[7:0] = s_reg.latch[7:0];
            OFS_A_PIN: rd_word[7:0] = pin_sync[7:0];
            OFS_B_DIRECTION: rd_word[7:0] = s_reg.dir[15:8];
            OFS_B_LATCH: rd_word[7:0] = s_reg.latch[15:8];
            OFS_B_PIN: rd_word[7:0] = pin_sync[15:8];
            default: rd_resp = AXI_RESP_SLVERR;
        endcase
        if (s_axi_araddr[31:8] != 24'h00_0000) begin
            rd_word = 32'h0000_0000;
            rd_resp = AXI_RESP_SLVERR;
        end
    end

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        s_next = s_reg;
        sw_toggle = '0;
        latch_base = s_reg.latch;
        wr_resp = AXI_RESP_OKAY;
        if (s_axi_awvalid && s_axi_awready) begin
            s_next.aw_held = 1'b1;
            s_next.aw_addr = (s_axi_awaddr[31:8] == 24'h00_0000) ? s_axi_awaddr[7:0] : 8'hFF;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            s_next.w_held = 1'b1;
            s_next.w_data = s_axi_wdata[7:0];
            s_next.w_lane0 = s_axi_wstrb[0];
        end
        // One write strobe per port register covers all its pins
        if (wr_fire) begin
            s_next.aw_held = 1'b0;
            s_next.w_held = 1'b0;
            s_next.bvalid = 1'b1;
            unique case (s_reg.aw_addr)
                OFS_MCU_CONTROL: if (s_reg.w_lane0) begin
                    s_next.mcu = s_reg.w_data & MCU_CONTROL_RW_MASK;
                end
                OFS_PORT_CONTROL: if (s_reg.w_lane0) begin
                    s_next.pcr = s_reg.w_data;
                end
                OFS_A_DIRECTION: if (s_reg.w_lane0) begin
                    s_next.dir[7:0] = s_reg.w_data;
                end
                OFS_A_LATCH: if (s_reg.w_lane0) begin
                    latch_base[7:0] = s_reg.w_data;
                end
                OFS_A_PIN: if (s_reg.w_lane0) begin
                    sw_toggle[7:0] = s_reg.w_data;
                end
                OFS_B_DIRECTION: if (s_reg.w_lane0) begin
                    s_next.dir[15:8] = s_reg.w_data;
                end
                OFS_B_LATCH: if (s_reg.w_lane0) begin
                    latch_base[15:8] = s_reg.w_data;
                end
                OFS_B_PIN: if (s_reg.w_lane0) begin
                    sw_toggle[15:8] = s_reg.w_data;
                end
                default: wr_resp = AXI_RESP_SLVERR;
            endcase
            s_next.bresp = wr_resp;
        end
        // Toggle applied on top of a same-cycle write so no event is lost
        s_next.latch = latch_base ^ sw_toggle ^ latch_toggle_override_en_i;
        if (s_reg.bvalid && s_axi_bready) begin
            s_next.bvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            s_next.rvalid = 1'b1;
            s_next.rdata = rd_word;
            s_next.rresp = rd_resp;
        end else if (s_reg.rvalid && s_axi_rready) begin
            s_next.rvalid = 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            s_reg <= CORE_RESET;
        end else begin
            s_reg <= s_next;
        end
    end

    // ****************************************
    // Pins
    // ****************************************
    for (genvar i = 0; i < PINS; i++) begin : g_pin
        localparam int PORT = i / PINS_PER_PORT;
        logic pull_off;
        logic break_first;
        // Global pull-off and sleep shared by every port
        assign pull_off = s_reg.mcu[MCU_GLOBAL_PULLUP_OFF_BIT] |
            s_reg.pcr[PCR_PORT_A_PULLUP_OFF_BIT + PORT];
        assign break_first = s_reg.pcr[PCR_PORT_A_BREAK_FIRST_BIT + PORT];
        pao_pin u_pin (
            .clk_i(clk_i),
            .reset_i(reset_i),
            .dir_bit_i(s_reg.dir[i]),
            .latch_bit_i(s_reg.latch[i]),
            .pullup_off_i(pull_off),
            .break_first_i(break_first),
            .sleep_i(sleep_i),
            .pullup_override_en_i(pullup_override_en_i[i]),
            .pullup_override_val_i(pullup_override_val_i[i]),
            .direction_override_en_i(direction_override_en_i[i]),
            .direction_override_val_i(direction_override_val_i[i]),
            .pin_value_override_en_i(pin_value_override_en_i[i]),
            .pin_value_override_val_i(pin_value_override_val_i[i]),
            .input_enable_override_en_i(input_enable_override_en_i[i]),
            .input_enable_override_val_i(input_enable_override_val_i[i]),
            .pad_in_i(pad_in_i[i]),
            .pad_out_o(pad_out_o[i]),
            .pad_oe_o(pad_oe_o[i]),
            .pullup_en_o(pullup_en_o[i]),
            .input_en_o(input_en_o[i]),
            .alt_func_pin_input_o(alt_func_pin_input_o[i]),
            .pin_sync_o(pin_sync[i])
        );
    end

    // ****************************************
    // Checks
    // ****************************************
    a_toggle_latch: assert property (@(posedge clk_i) disable iff (reset_i)
        (!wr_fire && latch_toggle_override_en_i[0]) |=> (s_reg.latch[0] != $past(s_reg.latch[0])))
        else $error("toggle did not invert latch");
    a_global_pullup: assert property (@(posedge clk_i) disable iff (reset_i)
        s_reg.mcu[MCU_GLOBAL_PULLUP_OFF_BIT] |->
        (pullup_en_o == (pullup_override_en_i & pullup_override_val_i)))
        else $error("pull-up on despite global off");
    a_port_pullup: assert property (@(posedge clk_i) disable iff (reset_i)
        (s_reg.pcr[PCR_PORT_B_PULLUP_OFF_BIT] && !pullup_override_en_i[8]) |-> !pullup_en_o[8])
        else $error("port pull-off ignored");
    a_reset_zero: assert property (@(posedge clk_i)
        $past(reset_i) && !reset_i |-> (s_reg.mcu == MCU_CONTROL_RESET && s_reg.pcr == '0))
        else $error("control registers not zero after reset");
    a_write_answer: assert property (@(posedge clk_i) disable iff (reset_i)
        wr_fire |=> s_axi_bvalid && !s_axi_awready && !s_axi_wready)
        else $error("write not answered next cycle");

    // ****************************************
    // Whole-port checks, pin 0 and pin 8 checks, and register and read checks
    // ****************************************
    a_pullup_value: assert property (
        ((pullup_en_o ^ pullup_override_val_i) & pullup_override_en_i) == '0)
        else $error("pull-up not override value");
    a_pullup_pin_a: assert property (
        !pullup_override_en_i[0] |-> pullup_en_o[0] == (!s_reg.dir[0] && s_reg.latch[0] &&
        !global_pullup_off_o && !s_reg.pcr[PCR_PORT_A_PULLUP_OFF_BIT]))
        else $error("pull-up wrong on pin 0");
    a_pullup_pin_b: assert property (
        !pullup_override_en_i[8] |-> pullup_en_o[8] == (!s_reg.dir[8] && s_reg.latch[8] &&
        !global_pullup_off_o && !s_reg.pcr[PCR_PORT_B_PULLUP_OFF_BIT]))
        else $error("pull-up wrong on pin 8");
    a_dir_forced_off: assert property (
        (pad_oe_o & direction_override_en_i & ~direction_override_val_i) == '0)
        else $error("driver on against override");
    a_dir_source: assert property (
        !s_reg.pcr[PCR_PORT_A_BREAK_FIRST_BIT] && !s_reg.pcr[PCR_PORT_B_BREAK_FIRST_BIT] |->
        pad_oe_o == ((direction_override_en_i & direction_override_val_i) |
        (~direction_override_en_i & s_reg.dir)))
        else $error("driver enable wrong source");
    a_gap_port_b_off: assert property (
        !s_reg.pcr[PCR_PORT_B_BREAK_FIRST_BIT] |-> pad_oe_o[8] ==
        (direction_override_en_i[8] ? direction_override_val_i[8] : s_reg.dir[8]))
        else $error("gap on port B with break off");
    a_value_override: assert property (
        ((pad_out_o ^ pin_value_override_val_i) & pad_oe_o & pin_value_override_en_i) == '0)
        else $error("pin not at override value");
    a_value_latch: assert property (
        ((pad_out_o ^ s_reg.latch) & pad_oe_o & ~pin_value_override_en_i) == '0)
        else $error("pin not at latch value");
    a_hiz_all: assert property (
        (pad_out_o & ~pad_oe_o) == '0)
        else $error("value on undriven pin");
    a_input_override: assert property (
        ((input_en_o ^ input_enable_override_val_i) & input_enable_override_en_i) == '0)
        else $error("input enable not override");
    a_input_awake: assert property (
        !sleep_i |-> (~input_en_o & ~input_enable_override_en_i) == '0)
        else $error("input off while awake");
    a_alt_raw: assert property (
        alt_func_pin_input_o == (pad_in_i & input_en_o))
        else $error("alternate input not raw pad");
    a_toggle_all: assert property (
        !wr_fire |=> s_reg.latch == ($past(s_reg.latch) ^ $past(latch_toggle_override_en_i)))
        else $error("latch not toggled");
    a_ro_zero: assert property (
        (s_reg.mcu & ~MCU_CONTROL_RW_MASK) == 8'h00)
        else $error("read-only control bits set");
    a_read_answer: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read not answered");
    a_pcr_lands: assert property (
        wr_fire && s_reg.aw_addr == OFS_PORT_CONTROL && s_reg.w_lane0 |=>
        s_reg.pcr == $past(s_reg.w_data))
        else $error("port control write lost");
    a_mcu_lands: assert property (
        wr_fire && s_reg.aw_addr == OFS_MCU_CONTROL && s_reg.w_lane0 |=>
        global_pullup_off_o == $past(s_reg.w_data[MCU_GLOBAL_PULLUP_OFF_BIT]))
        else $error("global pull-off write lost");

endmodule

/* pao_pkg.sv */
package pao_pkg;

    // ****************************************
    // Geometry
    // ****************************************
    localparam int NUM_PORTS = 2;
    localparam int PINS_PER_PORT = 8;
    localparam int NUM_PINS = NUM_PORTS * PINS_PER_PORT;

    // ****************************************
    // Register offsets (byte addresses)
    // ****************************************
    localparam logic [7:0] OFS_MCU_CONTROL = 8'h00;
    localparam logic [7:0] OFS_PORT_CONTROL = 8'h04;
    localparam logic [7:0] OFS_A_DIRECTION = 8'h08;
    localparam logic [7:0] OFS_A_LATCH = 8'h0C;
    localparam logic [7:0] OFS_A_PIN = 8'h10;
    localparam logic [7:0] OFS_B_DIRECTION = 8'h14;
    localparam logic [7:0] OFS_B_LATCH = 8'h18;
    localparam logic [7:0] OFS_B_PIN = 8'h1C;

    // ****************************************
    // Fields and reset values
    // ****************************************
    localparam int MCU_GLOBAL_PULLUP_OFF_BIT = 4;
    localparam int MCU_BROWNOUT_SLEEP_UNLOCK_BIT = 5;
    localparam int MCU_BROWNOUT_SLEEP_OFF_BIT = 6;
    localparam logic [7:0] MCU_CONTROL_RW_MASK = 8'h70;
    localparam logic [7:0] MCU_CONTROL_RESET = 8'h00;
    localparam int PCR_PORT_A_PULLUP_OFF_BIT = 0;
    localparam int PCR_PORT_B_PULLUP_OFF_BIT = 1;
    localparam int PCR_PORT_A_BREAK_FIRST_BIT = 4;
    localparam int PCR_PORT_B_BREAK_FIRST_BIT = 5;
    localparam logic [7:0] PORT_CONTROL_RESET = 8'h00;
    localparam logic [7:0] PORT_REG_RESET = 8'h00;

    localparam logic [1:0] AXI_RESP_OKAY = 2'h0;
    localparam logic [1:0] AXI_RESP_SLVERR = 2'h2;

    // ****************************************
    // State records
    // ****************************************
    typedef struct packed {
        logic [7:0] mcu;
        logic [7:0] pcr;
        logic [NUM_PINS-1:0] dir;
        logic [NUM_PINS-1:0] latch;
        logic aw_held;
        logic [7:0] aw_addr;
        logic w_held;
        logic [7:0] w_data;
        logic w_lane0;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
    } pao_core_s;

    typedef struct packed {
        logic prev_oe;
        logic sync_meta;
        logic sync_out;
    } pao_pin_s;

    localparam pao_core_s CORE_RESET = '{
        mcu: MCU_CONTROL_RESET,
        pcr: PORT_CONTROL_RESET,
        dir: {NUM_PORTS{PORT_REG_RESET}},
        latch: {NUM_PORTS{PORT_REG_RESET}},
        default: '0
    };
    localparam pao_pin_s PIN_RESET = '0;

endpackage

/* pao_pin.sv */
`timescale 1ns/100ps
module pao_pin
    import pao_pkg::*;
(
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic dir_bit_i,
    input wire logic latch_bit_i,
    input wire logic pullup_off_i,
    input wire logic break_first_i,
    input wire logic sleep_i,
    input wire logic pullup_override_en_i,
    input wire logic pullup_override_val_i,
    input wire logic direction_override_en_i,
    input wire logic direction_override_val_i,
    input wire logic pin_value_override_en_i,
    input wire logic pin_value_override_val_i,
    input wire logic input_enable_override_en_i,
    input wire logic input_enable_override_val_i,
    input wire logic pad_in_i,
    output logic pad_out_o,
    output logic pad_oe_o,
    output logic pullup_en_o,
    output logic input_en_o,
    output logic alt_func_pin_input_o,
    output logic pin_sync_o
);

    pao_pin_s s_reg;
    pao_pin_s s_next;
    logic oe_req;
    logic break_gap;

    // ****************************************
    // Pad control
    // ****************************************
    always_comb begin
        oe_req = direction_override_en_i ? direction_override_val_i : dir_bit_i;
        // Gap only on a rising request; falling switches at once
        break_gap = break_first_i && oe_req && !s_reg.prev_oe;
        pad_oe_o = oe_req && !break_gap;
        pad_out_o = pad_oe_o &&
            (pin_value_override_en_i ? pin_value_override_val_i : latch_bit_i);
        if (pullup_override_en_i) begin
            pullup_en_o = pullup_override_val_i;
        end else begin
            pullup_en_o = !dir_bit_i && latch_bit_i && !pullup_off_i;
        end
        input_en_o = input_enable_override_en_i ? input_enable_override_val_i : !sleep_i;
        // Unsynchronised on purpose; consumers use it as clock or sync it
        alt_func_pin_input_o = pad_in_i && input_en_o;
        pin_sync_o = s_reg.sync_out;
        s_next.prev_oe = oe_req;
        s_next.sync_meta = alt_func_pin_input_o;
        s_next.sync_out = s_reg.sync_meta;
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            s_reg <= PIN_RESET;
        end else begin
            s_reg <= s_next;
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    a_break_gap: assert property (@(posedge clk_i) disable iff (reset_i)
        (break_first_i && oe_req && !s_reg.prev_oe) |-> !pad_oe_o)
        else $error("break gap missing");
    a_break_one_cycle: assert property (@(posedge clk_i) disable iff (reset_i)
        (break_first_i && oe_req && !s_reg.prev_oe) ##1 oe_req |-> pad_oe_o)
        else $error("break gap longer than one cycle");
    a_off_no_gap: assert property (@(posedge clk_i) disable iff (reset_i)
        (s_reg.prev_oe && !oe_req) |-> !pad_oe_o)
        else $error("driver stayed on after turn off");
    a_pullup_override: assert property (@(posedge clk_i) disable iff (reset_i)
        pullup_override_en_i |-> (pullup_en_o == pullup_override_val_i))
        else $error("pull-up ignores override");
    a_hiz_no_drive: assert property (@(posedge clk_i) disable iff (reset_i)
        !pad_oe_o |-> !pad_out_o)
        else $error("value driven while off");
    a_input_sleep: assert property (@(posedge clk_i) disable iff (reset_i)
        !input_enable_override_en_i |-> (input_en_o == !sleep_i))
        else $error("input enable not following sleep");
    a_sync_delay: assert property (@(posedge clk_i) disable iff (reset_i)
        ##2 (pin_sync_o == $past(alt_func_pin_input_o, 2)))
        else $error("sync path not two stages");

endmodule

/* pao_periph_model.sv */
`timescale 1ns/100ps
module pao_periph_model (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic [8:0][15:0] cmd_i,
    input wire logic [15:0] alt_in_i,
    output logic [8:0][15:0] ovr_o,
    output logic [15:0] alt_sync_o
);
    // ****************************************
    // Override launch and input capture
    // ****************************************
    logic [15:0] meta_reg;

    // Launched just after the edge, as a real peripheral would
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            ovr_o <= '0;
            meta_reg <= '0;
            alt_sync_o <= '0;
        end else begin
            ovr_o <= cmd_i;
            // Raw pad level arrives, so two local stages guard it
            meta_reg <= alt_in_i;
            alt_sync_o <= meta_reg;
        end
    end
endmodule

/* pao_core_tb.sv */
`timescale 1ns/100ps
module pao_core_tb;
    import pao_pkg::*;
    // ****************************************
    // Signals
    // ****************************************
    logic clk_i = 0;
    logic reset_i = 1;
    logic awvalid = 0, awready, wvalid = 0, wready, bvalid, bready = 0;
    logic arvalid = 0, arready, rvalid, rready = 0, sleep_i = 0;
    logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rdata;
    logic [3:0] wstrb = '0;
    logic [1:0] bresp, rresp;
    logic [8:0][15:0] cmd = '0;
    logic [8:0][15:0] ovr;
    logic [15:0] pad_in_i = '0, pad_out_o, pad_oe_o, pullup_en_o, input_en_o, alt_in, alt_sync;
    logic global_pullup_off_o, brownout_sleep_off_o, brownout_sleep_unlock_o;
    int miscompares = 0;
    int total_checks = 0;

    always #2.5 clk_i = ~clk_i;

    pao_core dut (.clk_i(clk_i), .reset_i(reset_i), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_bresp(bresp), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .sleep_i(sleep_i), .pullup_override_en_i(ovr[0]), .pullup_override_val_i(ovr[1]),
        .direction_override_en_i(ovr[2]), .direction_override_val_i(ovr[3]),
        .pin_value_override_en_i(ovr[4]), .pin_value_override_val_i(ovr[5]),
        .latch_toggle_override_en_i(ovr[6]), .input_enable_override_en_i(ovr[7]),
        .input_enable_override_val_i(ovr[8]), .pad_in_i(pad_in_i), .pad_out_o(pad_out_o),
        .pad_oe_o(pad_oe_o), .pullup_en_o(pullup_en_o), .input_en_o(input_en_o),
        .alt_func_pin_input_o(alt_in), .global_pullup_off_o(global_pullup_off_o),
        .brownout_sleep_off_o(brownout_sleep_off_o),
        .brownout_sleep_unlock_o(brownout_sleep_unlock_o));

    pao_periph_model periph (.clk_i(clk_i), .reset_i(reset_i), .cmd_i(cmd),
        .alt_in_i(alt_in), .ovr_o(ovr), .alt_sync_o(alt_sync));

    // ****************************************
    // Tasks
    // ****************************************
    task automatic test_done();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            $display("wrong value %s expected %h seen %h", nm, e, g);
            miscompares++;
        end
    endtask

    task automatic chkp(input string nm, input logic [15:0] e, input logic [15:0] g);
        chk(nm, {16'h0000, e}, {16'h0000, g});
    endtask

    task automatic hang();
        $display("wrong value handshake expected answer seen none");
        miscompares++;
        test_done();
    endtask

    // Both channels offered together, each released when its ready is seen
    task automatic axi_wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
        int n;
        logic [2:0] ok;
        logic [1:0] resp;
        @(posedge clk_i);
        awvalid <= 1;
        awaddr <= {24'h00_0000, a};
        wvalid <= 1;
        wdata <= {24'h00_0000, d};
        wstrb <= 4'hF;
        bready <= 1;
        for (n = 0; n < 50; n++) begin
            // Answers settle by mid-cycle; act on them just after the edge
            @(negedge clk_i);
            ok = {awvalid && awready, wvalid && wready, bvalid === 1'b1};
            resp = bresp;
            @(posedge clk_i);
            if (ok[2]) awvalid <= 0;
            if (ok[1]) wvalid <= 0;
            if (ok[0]) break;
        end
        if (n == 50) hang();
        bready <= 0;
        chk("bresp", {30'h0, er}, {30'h0, resp});
    endtask

    task automatic axi_rd(input logic [7:0] a, input logic [7:0] e, input logic [1:0] er);
        int n;
        logic [1:0] ok;
        logic [1:0] resp;
        logic [31:0] got;
        @(posedge clk_i);
        arvalid <= 1;
        araddr <= {24'h00_0000, a};
        rready <= 1;
        for (n = 0; n < 50; n++) begin
            @(negedge clk_i);
            ok = {arvalid && arready, rvalid === 1'b1};
            resp = rresp;
            got = rdata;
            @(posedge clk_i);
            if (ok[1]) arvalid <= 0;
            if (ok[0]) break;
        end
        if (n == 50) hang();
        rready <= 0;
        chk("rresp", {30'h0, er}, {30'h0, resp});
        chk("rdata", {24'h00_0000, e}, got);
    endtask

    task automatic set_ovr(input int i, input logic [15:0] v);
        @(posedge clk_i);
        cmd[i] <= v;
    endtask

    task automatic settle();
        repeat (2) @(posedge clk_i);
        @(negedge clk_i);
    endtask

    // Samples driver enable of pins 0 and 8 on four falling edges
    task automatic bbm(input logic [15:0] v, input logic [3:0] e0, input logic [3:0] e8);
        logic [3:0] s0, s8;
        @(posedge clk_i);
        cmd[2] <= 16'h0101;
        cmd[3] <= v;
        for (int k = 0; k < 4; k++) begin
            @(negedge clk_i);
            s0 = {s0[2:0], pad_oe_o[0]};
            s8 = {s8[2:0], pad_oe_o[8]};
        end
        chk("oe pin0", {28'h0, e0}, {28'h0, s0});
        chk("oe pin8", {28'h0, e8}, {28'h0, s8});
    endtask

    // ****************************************
    // Tests
    // ****************************************
    initial begin
        repeat (6) @(posedge clk_i);
        reset_i <= 0;
        axi_rd(OFS_MCU_CONTROL, 8'h00, AXI_RESP_OKAY);
        axi_rd(OFS_PORT_CONTROL, 8'h00, AXI_RESP_OKAY);
        axi_wr(OFS_MCU_CONTROL, 8'hFF, AXI_RESP_OKAY);
        axi_rd(OFS_MCU_CONTROL, 8'h70, AXI_RESP_OKAY);
        chkp("mcu bits", 16'h0007, {13'h0, brownout_sleep_off_o, brownout_sleep_unlock_o,
            global_pullup_off_o});
        axi_wr(OFS_PORT_CONTROL, 8'hCF, AXI_RESP_OKAY);
        axi_rd(OFS_PORT_CONTROL, 8'hCF, AXI_RESP_OKAY);
        axi_wr(8'h20, 8'h11, AXI_RESP_SLVERR);
        axi_rd(8'h20, 8'h00, AXI_RESP_SLVERR);
        $display("register test done");

        axi_wr(OFS_MCU_CONTROL, 8'h00, AXI_RESP_OKAY);
        axi_wr(OFS_PORT_CONTROL, 8'h00, AXI_RESP_OKAY);
        axi_wr(OFS_A_LATCH, 8'hFF, AXI_RESP_OKAY);
        axi_wr(OFS_B_LATCH, 8'hFF, AXI_RESP_OKAY);
        settle();
        chkp("pullup", 16'hFFFF, pullup_en_o);
        axi_wr(OFS_PORT_CONTROL, 8'h01, AXI_RESP_OKAY);
        settle();
        chkp("pullup", 16'hFF00, pullup_en_o);
        axi_wr(OFS_MCU_CONTROL, 8'h10, AXI_RESP_OKAY);
        settle();
        chkp("pullup", 16'h0000, pullup_en_o);
        set_ovr(0, 16'hFFFF);
        set_ovr(1, 16'hA5A5);
        settle();
        chkp("pullup", 16'hA5A5, pullup_en_o);
        set_ovr(0, 16'h0000);
        $display("pullup test done");

        axi_wr(OFS_MCU_CONTROL, 8'h00, AXI_RESP_OKAY);
        axi_wr(OFS_A_DIRECTION, 8'h0F, AXI_RESP_OKAY);
        axi_wr(OFS_A_LATCH, 8'h05, AXI_RESP_OKAY);
        settle();
        chkp("oe", 16'h000F, pad_oe_o);
        chkp("out", 16'h0005, pad_out_o);
        set_ovr(2, 16'hFFFF);
        set_ovr(3, 16'hF0F0);
        settle();
        chkp("oe", 16'hF0F0, pad_oe_o);
        chkp("out", 16'hF000, pad_out_o);
        set_ovr(4, 16'hFFFF);
        set_ovr(5, 16'h3C3C);
        settle();
        chkp("out", 16'h3030, pad_out_o);
        set_ovr(6, 16'h0001);
        set_ovr(6, 16'h0000);
        axi_rd(OFS_A_LATCH, 8'h04, AXI_RESP_OKAY);
        axi_wr(OFS_A_PIN, 8'h02, AXI_RESP_OKAY);
        axi_rd(OFS_A_LATCH, 8'h06, AXI_RESP_OKAY);
        cmd <= '0;
        $display("driver test done");

        pad_in_i <= 16'h5AC3;
        settle();
        chkp("input en", 16'hFFFF, input_en_o);
        chkp("alt in", 16'h5AC3, alt_in);
        chkp("alt sync", 16'h5AC3, alt_sync);
        axi_rd(OFS_A_PIN, 8'hC3, AXI_RESP_OKAY);
        axi_rd(OFS_B_PIN, 8'h5A, AXI_RESP_OKAY);
        sleep_i <= 1;
        settle();
        chkp("input en", 16'h0000, input_en_o);
        set_ovr(7, 16'hFFFF);
        set_ovr(8, 16'h00FF);
        settle();
        chkp("input en", 16'h00FF, input_en_o);
        chkp("alt in", 16'h00C3, alt_in);
        sleep_i <= 0;
        cmd <= '0;
        $display("input test done");

        axi_wr(OFS_A_DIRECTION, 8'h00, AXI_RESP_OKAY);
        axi_wr(OFS_PORT_CONTROL, 8'h10, AXI_RESP_OKAY);
        bbm(16'h0101, 4'b0011, 4'b0111);
        bbm(16'h0000, 4'b1000, 4'b1000);
        axi_wr(OFS_PORT_CONTROL, 8'h20, AXI_RESP_OKAY);
        bbm(16'h0101, 4'b0111, 4'b0011);
        $display("break test done");
        test_done();
    end
endmodule
